//--- capture_pixel_formatter_pkg.sv
// Constants for the per-field capture pixel formatter
package capture_pixel_formatter_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [11:0] FMT_OFFSET = 12'h0d4;
   localparam logic [11:0] CTL_OFFSET = 12'h0d8;
   localparam logic [11:0] CAPEN_OFFSET = 12'h0dc;
   localparam logic [11:0] STAT_OFFSET = 12'h0ec;
   localparam logic [7:0] FMT_RESET = 8'h00;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CAPEN_RESET = 8'h00;
   localparam int ODD_FMT_LSB = 4;
   localparam int EVEN_FMT_LSB = 0;
   localparam int STD_BIT = 7;
   localparam int BARS_BIT = 6;
   localparam int DIFF_DIS_BIT = 5;
   localparam int GAMMA_DIS_BIT = 4;
   localparam int ODD_HW_BIT = 3;
   localparam int EVEN_HW_BIT = 2;
   localparam int ODD_BX_BIT = 1;
   localparam int EVEN_BX_BIT = 0;
   localparam int CAP_ODD_BIT = 1;
   localparam int CAP_EVEN_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ****************************************
   // Format codes
   // ****************************************
   localparam logic [3:0] FMT_RGB32 = 4'h0;
   localparam logic [3:0] FMT_RGB24 = 4'h1;
   localparam logic [3:0] FMT_RGB16 = 4'h2;
   localparam logic [3:0] FMT_RGB15 = 4'h3;
   localparam logic [3:0] FMT_YUV422 = 4'h4;
   localparam logic [3:0] FMT_YUV411 = 4'h5;
   localparam logic [3:0] FMT_GREY = 4'h6;
   localparam logic [3:0] FMT_RGB8 = 4'h7;
   localparam logic [3:0] FMT_PLANAR422 = 4'h8;
   localparam logic [3:0] FMT_PLANAR411 = 4'h9;
   localparam logic [3:0] FMT_RAW = 4'he;
   localparam int BAR_LSB = 7;
endpackage

//--- capture_pixel_formatter.sv
// Per-field pixel formatter with AXI4-Lite register slave
// Behaviour
// - Odd field format from bits 7:4
// - Even field format from bits 3:0
// - Codes 0-6: RGB32/24/16/15, YUV422/411, grey
// - Codes 7,8,9,14 dithered/planar/raw; others reserved
// - Planar 4:1:1 serves 9 and 12 bit
// - Bit 7 gives standard in serial mode
// - Bit 6 injects colour bars at input
// - Bit 5 clear: diffuse error in RGB16/15
// - Bit 4 clear: remove gamma 2.2/2.8
// - Bit 3: exchange halfwords, odd field
// - Bit 2: exchange halfwords, even field
// - Bit 1: exchange bytes in halves, odd
// - Bit 0: exchange bytes in halves, even
// - Write FIFO only when parity capture enabled
`timescale 1ns/1ps
module capture_pixel_formatter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic field_start,
   input wire logic field_odd,
   input wire logic line_start,
   input wire logic pix_valid,
   input wire logic [7:0] pix_r,
   input wire logic [7:0] pix_g,
   input wire logic [7:0] pix_b,
   input wire logic [7:0] pix_y,
   input wire logic [7:0] pix_cb,
   input wire logic [7:0] pix_cr,
   input wire logic decoder_625,
   input wire logic gpio_spi16_mode,
   output logic [31:0] fifo_wdata,
   output logic fifo_wvalid,
   output logic [3:0] field_format
);
   // ****************************************
   // Register slave
   // ****************************************
   logic [7:0] fmt_q, fmt_d, ctl_q, ctl_d, capen_q, capen_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d;
   logic ws_q, ws_d, awh_q, awh_d, wh_q, wh_d;
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr;
   logic [7:0] stat;
   logic odd_q, cap_q, std625;
   logic [3:0] fmt_cur_q;

   always_comb begin
      fmt_d = fmt_q;
      ctl_d = ctl_q;
      capen_d = capen_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      awh_d = awh_q;
      wh_d = wh_q;
      bvalid_d = bvalid_q && !bready;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q && !rready;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (awvalid && awready_q) begin
         awa_d = awaddr;
         awh_d = 1'b1;
      end
      if (wvalid && wready_q) begin
         wd_d = wdata;
         ws_d = wstrb[0];
         wh_d = 1'b1;
      end
      do_wr = awh_q && wh_q && !bvalid_q;
      if (do_wr) begin
         awh_d = 1'b0;
         wh_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = capture_pixel_formatter_pkg::RESP_OKAY;
         unique case (awa_q[11:2])
            capture_pixel_formatter_pkg::FMT_OFFSET[11:2]:
               if (ws_q) fmt_d = wd_q[7:0];
            capture_pixel_formatter_pkg::CTL_OFFSET[11:2]:
               if (ws_q) ctl_d = wd_q[7:0];
            capture_pixel_formatter_pkg::CAPEN_OFFSET[11:2]:
               if (ws_q) capen_d = {6'h00, wd_q[1:0]};
            capture_pixel_formatter_pkg::STAT_OFFSET[11:2]: ;
            default: bresp_d = capture_pixel_formatter_pkg::RESP_SLVERR;
         endcase
      end
      if (arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = capture_pixel_formatter_pkg::RESP_OKAY;
         unique case (araddr[11:2])
            capture_pixel_formatter_pkg::FMT_OFFSET[11:2]: rdata_d = {24'h00_0000, fmt_q};
            capture_pixel_formatter_pkg::CTL_OFFSET[11:2]: rdata_d = {24'h00_0000, ctl_q};
            capture_pixel_formatter_pkg::CAPEN_OFFSET[11:2]: rdata_d = {24'h00_0000, capen_q};
            capture_pixel_formatter_pkg::STAT_OFFSET[11:2]: rdata_d = {24'h00_0000, stat};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = capture_pixel_formatter_pkg::RESP_SLVERR;
            end
         endcase
      end
      awready_d = !awh_d && !bvalid_d;
      wready_d = !wh_d && !bvalid_d;
      arready_d = !rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_q <= capture_pixel_formatter_pkg::FMT_RESET;
         ctl_q <= capture_pixel_formatter_pkg::CTL_RESET;
         capen_q <= capture_pixel_formatter_pkg::CAPEN_RESET;
         awa_q <= 12'h000;
         wd_q <= 32'h0000_0000;
         ws_q <= 1'b0;
         awh_q <= 1'b0;
         wh_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= 2'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         fmt_q <= fmt_d;
         ctl_q <= ctl_d;
         capen_q <= capen_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         awh_q <= awh_d;
         wh_q <= wh_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Format conversion stage
   // ****************************************
   logic hw_q, bx_q, line_odd_q;
   logic [9:0] pcnt_q;
   logic [63:0] acc_q, acc_d;
   logic [3:0] cnt_q, cnt_d;
   logic [2:0] er_q, eg_q, eb_q, er_d, eg_d, eb_d;
   logic [31:0] out_d, raw_d, raw_q;
   logic outv_d, outv_q, take;
   logic [7:0] r, g, b, y, cb, cr;
   logic [31:0] by;
   logic [2:0] nb;
   logic [3:0] dv;
   logic [63:0] sum;
   logic [7:0] sr, sg, sb;

   function automatic logic [7:0] lin(input logic [7:0] x, input logic p);
      logic [15:0] sq, cu;
      sq = x * x;
      cu = sq[15:8] * x;
      return p ? cu[15:8] : sq[15:8];
   endfunction

   function automatic logic [10:0] dif(input logic [7:0] x, input logic [2:0] e,
                                       input logic two);
      logic [8:0] s;
      s = {1'b0, x} + {6'h00, e};
      if (s[8]) s = 9'h0ff;
      if (two) return {s[7:2], 2'h0, 1'b0, s[1:0]};
      return {s[7:3], 3'h0, s[2:0]};
   endfunction

   function automatic logic [7:0] sat(input logic [7:0] x, input logic [3:0] d);
      logic [8:0] s;
      s = {1'b0, x} + {1'b0, d, 4'h0};
      return s[8] ? 8'hff : s[7:0];
   endfunction

   assign std625 = gpio_spi16_mode ? ctl_q[capture_pixel_formatter_pkg::STD_BIT]
                                   : decoder_625;
   assign stat = {1'b0, std625, cap_q, odd_q, fmt_cur_q};
   assign take = pix_valid && cap_q && !field_start;

   always_comb begin
      logic [10:0] qr, qg, qb;
      logic [2:0] idx;
      qr = 11'h000;
      qg = 11'h000;
      qb = 11'h000;
      idx = pcnt_q[capture_pixel_formatter_pkg::BAR_LSB +: 3];
      if (ctl_q[capture_pixel_formatter_pkg::BARS_BIT]) begin
         r = idx[2] ? 8'hbf : 8'h00;
         g = idx[1] ? 8'hbf : 8'h00;
         b = idx[0] ? 8'hbf : 8'h00;
         y = {1'b0, idx[1], idx[2], idx[0], 4'h0};
         cb = 8'h80;
         cr = 8'h80;
      end else begin
         r = pix_r;
         g = pix_g;
         b = pix_b;
         y = pix_y;
         cb = pix_cb;
         cr = pix_cr;
      end
      if (!ctl_q[capture_pixel_formatter_pkg::GAMMA_DIS_BIT]) begin
         r = lin(r, std625);
         g = lin(g, std625);
         b = lin(b, std625);
      end
      er_d = er_q;
      eg_d = eg_q;
      eb_d = eb_q;
      if (fmt_cur_q == capture_pixel_formatter_pkg::FMT_RGB16 ||
          fmt_cur_q == capture_pixel_formatter_pkg::FMT_RGB15) begin
         qr = dif(r, er_q, 1'b0);
         qg = dif(g, eg_q, fmt_cur_q == capture_pixel_formatter_pkg::FMT_RGB16);
         qb = dif(b, eb_q, 1'b0);
         r = qr[10:3];
         g = qg[10:3];
         b = qb[10:3];
         if (take) begin
            er_d = qr[2:0];
            eg_d = qg[2:0];
            eb_d = qb[2:0];
         end
         if (ctl_q[capture_pixel_formatter_pkg::DIFF_DIS_BIT]) begin
            er_d = 3'h0;
            eg_d = 3'h0;
            eb_d = 3'h0;
         end
      end
      if (line_start || field_start) begin
         er_d = 3'h0;
         eg_d = 3'h0;
         eb_d = 3'h0;
      end
      dv = {1'b0, pcnt_q[0], line_odd_q, 1'b0};
      by = 32'h0000_0000;
      nb = 3'h0;
      sr = sat(r, dv);
      sg = sat(g, dv);
      sb = sat(b, {dv[2:0], 1'b0});
      unique case (fmt_cur_q)
         capture_pixel_formatter_pkg::FMT_RGB32: begin
            by = {8'h00, r, g, b};
            nb = 3'h4;
         end
         capture_pixel_formatter_pkg::FMT_RGB24: begin
            by = {8'h00, r, g, b};
            nb = 3'h3;
         end
         capture_pixel_formatter_pkg::FMT_RGB16: begin
            by = {16'h0000, r[7:3], g[7:2], b[7:3]};
            nb = 3'h2;
         end
         capture_pixel_formatter_pkg::FMT_RGB15: begin
            by = {16'h0000, 1'b0, r[7:3], g[7:3], b[7:3]};
            nb = 3'h2;
         end
         capture_pixel_formatter_pkg::FMT_YUV422,
         capture_pixel_formatter_pkg::FMT_PLANAR422: begin
            by = {16'h0000, pcnt_q[0] ? cr : cb, y};
            nb = 3'h2;
         end
         capture_pixel_formatter_pkg::FMT_YUV411,
         capture_pixel_formatter_pkg::FMT_PLANAR411: begin
            by = {16'h0000, pcnt_q[1] ? cr : cb, y};
            nb = pcnt_q[0] ? 3'h1 : 3'h2;
         end
         capture_pixel_formatter_pkg::FMT_GREY,
         capture_pixel_formatter_pkg::FMT_RAW: begin
            by = {24'h00_0000, y};
            nb = 3'h1;
         end
         capture_pixel_formatter_pkg::FMT_RGB8: begin
            by = {24'h00_0000, sr[7:5], sg[7:5], sb[7:6]};
            nb = 3'h1;
         end
         default: ;
      endcase
      acc_d = acc_q;
      cnt_d = cnt_q;
      outv_d = 1'b0;
      sum = acc_q | ({32'h0000_0000, by} << {cnt_q, 3'h0});
      raw_d = sum[31:0];
      if (field_start) begin
         acc_d = 64'h0000_0000_0000_0000;
         cnt_d = 4'h0;
      end else if (take) begin
         acc_d = sum;
         cnt_d = cnt_q + {1'b0, nb};
         if (cnt_d >= 4'h4) begin
            outv_d = 1'b1;
            acc_d = sum >> 32;
            cnt_d = cnt_d - 4'h4;
         end
      end
      out_d = raw_d;
      if (hw_q) out_d = {out_d[15:0], out_d[31:16]};
      if (bx_q) out_d = {out_d[23:16], out_d[31:24], out_d[7:0], out_d[15:8]};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         odd_q <= 1'b0;
         cap_q <= 1'b0;
         fmt_cur_q <= 4'h0;
         hw_q <= 1'b0;
         bx_q <= 1'b0;
         line_odd_q <= 1'b0;
         pcnt_q <= 10'h000;
         acc_q <= 64'h0000_0000_0000_0000;
         cnt_q <= 4'h0;
         er_q <= 3'h0;
         eg_q <= 3'h0;
         eb_q <= 3'h0;
         outv_q <= 1'b0;
         raw_q <= 32'h0000_0000;
         fifo_wdata <= 32'h0000_0000;
      end else begin
         if (field_start) begin
            odd_q <= field_odd;
            cap_q <= field_odd ? capen_q[capture_pixel_formatter_pkg::CAP_ODD_BIT]
                               : capen_q[capture_pixel_formatter_pkg::CAP_EVEN_BIT];
            fmt_cur_q <= field_odd ? fmt_q[capture_pixel_formatter_pkg::ODD_FMT_LSB +: 4]
                                   : fmt_q[capture_pixel_formatter_pkg::EVEN_FMT_LSB +: 4];
            hw_q <= ctl_q[field_odd ? capture_pixel_formatter_pkg::ODD_HW_BIT
                                    : capture_pixel_formatter_pkg::EVEN_HW_BIT];
            bx_q <= ctl_q[field_odd ? capture_pixel_formatter_pkg::ODD_BX_BIT
                                    : capture_pixel_formatter_pkg::EVEN_BX_BIT];
            line_odd_q <= 1'b0;
         end else if (line_start) begin
            line_odd_q <= !line_odd_q;
         end
         pcnt_q <= (field_start || line_start) ? 10'h000 : pcnt_q + {9'h000, pix_valid};
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         er_q <= er_d;
         eg_q <= eg_d;
         eb_q <= eb_d;
         outv_q <= outv_d;
         raw_q <= raw_d;
         if (outv_d) fifo_wdata <= out_d;
      end
   end

   assign fifo_wvalid = outv_q;
   assign field_format = fmt_cur_q;
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   fmt_reset_a: assert property ($past(!aresetn) |-> fmt_q == 8'h00)
      else $error("format register not cleared by reset");
   fmt_write_a: assert property (do_wr && ws_q && awa_q[11:2] == 10'h035
      |=> fmt_q[3:0] == $past(wd_q[3:0]) && fmt_q[7:4] == $past(wd_q[7:4]))
      else $error("format write lost");
   field_latch_a: assert property (field_start && field_odd
      |=> fmt_cur_q == $past(fmt_q[7:4]) && hw_q == $past(ctl_q[3]))
      else $error("odd field settings not latched");
   cap_gate_a: assert property (fifo_wvalid |-> $past(cap_q) && $past(pix_valid))
      else $error("FIFO written without capture enable");
   word32_a: assert property (take && fmt_cur_q == 4'h0 |=> fifo_wvalid)
      else $error("32-bit pixel did not emit a word");
   reserved_a: assert property (fmt_cur_q == 4'ha |=> !fifo_wvalid)
      else $error("reserved format wrote data");
   hw_swap_a: assert property (fifo_wvalid && hw_q && !bx_q && !$past(field_start)
      |-> fifo_wdata == {raw_q[15:0], raw_q[31:16]})
      else $error("halfword exchange wrong");
   bx_swap_a: assert property (fifo_wvalid && bx_q && !hw_q && !$past(field_start)
      |-> fifo_wdata == {raw_q[23:16], raw_q[31:24], raw_q[7:0], raw_q[15:8]})
      else $error("byte exchange wrong");
   diff_off_a: assert property (ctl_q[5] && take && fmt_cur_q == 4'h2
      |=> er_q == 3'h0 && eb_q == 3'h0)
      else $error("diffusion error kept while disabled");
   std_sel_a: assert property (gpio_spi16_mode |-> stat[6] == ctl_q[7])
      else $error("standard select ignores control bit");
   cov_odd_c: cover property (field_start && field_odd ##[1:50] fifo_wvalid);
   cov_swap_c: cover property (fifo_wvalid && hw_q && bx_q);
   cov_rd_c: cover property (rvalid && rready);
endmodule // capture_pixel_formatter

//--- capture_fifo_model.sv
// Capture FIFO model that collects words written by the formatter
`timescale 1ns/1ps
module capture_fifo_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] fifo_wdata,
   input wire logic fifo_wvalid
);
   logic [31:0] words [$];
   // *****
   // Word capture
   // *****
   // The FIFO never refuses, so each cycle with fifo_wvalid high stores one word
   always @(posedge aclk) begin
      if (aresetn === 1'b1 && fifo_wvalid === 1'b1) begin
         words.push_back(fifo_wdata);
      end
   end
endmodule // capture_fifo_model

//--- test_capture_pixel_formatter.sv
// Self-checking bench for the capture pixel formatter
`timescale 1ns/1ps
module test_capture_pixel_formatter;
   localparam logic [11:0] A_FMT = capture_pixel_formatter_pkg::FMT_OFFSET;
   localparam logic [11:0] A_CTL = capture_pixel_formatter_pkg::CTL_OFFSET;
   localparam logic [11:0] A_CAP = capture_pixel_formatter_pkg::CAPEN_OFFSET;
   localparam logic [11:0] A_STAT = capture_pixel_formatter_pkg::STAT_OFFSET;
   localparam logic [15:0] RES_CODES = 16'hbc00;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h1;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic field_start = 1'b0;
   logic field_odd = 1'b0;
   logic line_start = 1'b0;
   logic pix_valid = 1'b0;
   logic [7:0] pix_r = 8'h00;
   logic [7:0] pix_g = 8'h00;
   logic [7:0] pix_b = 8'h00;
   logic [7:0] pix_y = 8'h00;
   logic [7:0] pix_cb = 8'h00;
   logic [7:0] pix_cr = 8'h00;
   logic decoder_625 = 1'b0;
   logic gpio_spi16_mode = 1'b0;
   logic [31:0] fifo_wdata;
   logic fifo_wvalid;
   logic [3:0] field_format;
   logic [31:0] rd;
   logic [1:0] rsp;
   int fails = 0;
   int n_compared = 0;
   logic [7:0] ctl_tab [6] = '{8'h10, 8'h18, 8'h12, 8'h14, 8'h11, 8'h1f};
   logic [31:0] odd_tab [6] = '{32'h0011_2233, 32'h2233_0011, 32'h1100_3322,
      32'h0011_2233, 32'h0011_2233, 32'h3322_1100};
   logic [31:0] even_tab [6] = '{32'h0403_0201, 32'h0403_0201, 32'h0403_0201,
      32'h0201_0403, 32'h0304_0102, 32'h0102_0304};

   always #25 aclk = ~aclk;

   capture_pixel_formatter uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .field_start(field_start), .field_odd(field_odd),
      .line_start(line_start), .pix_valid(pix_valid), .pix_r(pix_r), .pix_g(pix_g),
      .pix_b(pix_b), .pix_y(pix_y), .pix_cb(pix_cb), .pix_cr(pix_cr),
      .decoder_625(decoder_625), .gpio_spi16_mode(gpio_spi16_mode),
      .fifo_wdata(fifo_wdata), .fifo_wvalid(fifo_wvalid), .field_format(field_format));

   capture_fifo_model fifo (.aclk(aclk), .aresetn(aresetn), .fifo_wdata(fifo_wdata),
      .fifo_wvalid(fifo_wvalid));

   // *****
   // Reporting and comparison
   // *****
   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s response %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic timed_out();
      fails++;
      $display("mismatch at %0t: handshake wait ran out", $time);
      summarize();
   endtask
   // *****
   // Register bus and pixel stream drivers
   // *****
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (n > 50) timed_out();
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (n > 50) timed_out();
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   task automatic field(input logic odd);
      @(posedge aclk);
      field_start <= 1'b1;
      field_odd <= odd;
      line_start <= 1'b1;
      @(posedge aclk);
      field_start <= 1'b0;
      line_start <= 1'b0;
   endtask
   task automatic pix(input logic [7:0] r, g, b, y, c);
      @(posedge aclk);
      pix_valid <= 1'b1;
      pix_r <= r;
      pix_g <= g;
      pix_b <= b;
      pix_y <= y;
      pix_cb <= c;
      pix_cr <= ~c;
   endtask
   task automatic pix_end();
      @(posedge aclk);
      pix_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task automatic expect_words(input logic [31:0] e[$], input string what);
      cmp_word(32'(fifo.words.size()), 32'(e.size()), what);
      foreach (e[i]) if (i < fifo.words.size()) cmp_word(fifo.words[i], e[i], what);
      fifo.words.delete();
   endtask
   task automatic expect_count(input int n, input string what);
      cmp_word(32'(fifo.words.size()), 32'(n), what);
      fifo.words.delete();
   endtask
   // *****
   // Test sequence
   // *****
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(A_FMT);
      cmp_word(rd, 32'(capture_pixel_formatter_pkg::FMT_RESET), "format reset");
      axi_read(A_CTL);
      cmp_word(rd, 32'(capture_pixel_formatter_pkg::CTL_RESET), "control reset");
      axi_read(12'h0e0);
      cmp_resp(rsp, capture_pixel_formatter_pkg::RESP_SLVERR, "unmapped read");
      cmp_word(rd, 32'h0000_0000, "unmapped data");
      axi_write(12'h0e0, 8'h55);
      cmp_resp(rsp, capture_pixel_formatter_pkg::RESP_SLVERR, "unmapped write");
      axi_write(A_FMT, 8'h96);
      cmp_resp(rsp, capture_pixel_formatter_pkg::RESP_OKAY, "format write");
      axi_read(A_FMT);
      cmp_word(rd, 32'h0000_0096, "format readback");
      $display("test registers done");
      axi_write(A_CAP, 8'h03);
      for (int k = 0; k < 16; k++) begin
         axi_write(A_FMT, {4'(k), 4'(15 - k)});
         field(1'b1);
         repeat (2) @(posedge aclk);
         if (!RES_CODES[k]) cmp_word(32'(field_format), 32'(k), "odd code");
         field(1'b0);
         repeat (2) @(posedge aclk);
         if (!RES_CODES[15 - k]) cmp_word(32'(field_format), 32'(15 - k), "even code");
      end
      axi_write(A_CTL, 8'h10);
      axi_write(A_FMT, 8'ha6);
      field(1'b1);
      for (int k = 1; k < 5; k++) pix(8'h00, 8'h00, 8'h00, 8'(k), 8'h00);
      pix_end();
      expect_count(0, "reserved code output");
      $display("test codes done");
      axi_write(A_FMT, 8'h06);
      for (int i = 0; i < 6; i++) begin
         axi_write(A_CTL, ctl_tab[i]);
         field(1'b1);
         pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
         pix_end();
         expect_words('{odd_tab[i]}, "odd swap");
         field(1'b0);
         for (int k = 1; k < 5; k++) pix(8'h00, 8'h00, 8'h00, 8'(k), 8'h00);
         pix_end();
         expect_words('{even_tab[i]}, "even swap");
      end
      $display("test swaps done");
      axi_write(A_CTL, 8'h10);
      axi_write(A_FMT, 8'h00);
      for (int c = 1; c < 3; c++) begin
         axi_write(A_CAP, 8'(c));
         for (int f = 0; f < 2; f++) begin
            field(f[0]);
            pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
            pix_end();
            expect_count(c[f] ? 1 : 0, "capture enable");
         end
      end
      $display("test capture enable done");
      axi_write(A_CAP, 8'h03);
      field(1'b1);
      pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
      pix_end();
      axi_write(A_CTL, 8'h18);
      axi_write(A_FMT, 8'h60);
      pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
      pix_end();
      expect_words('{32'h0011_2233, 32'h0011_2233}, "mid field change");
      cmp_word(32'(field_format), 32'h0000_0000, "format held");
      field(1'b1);
      for (int k = 1; k < 5; k++) pix(8'h00, 8'h00, 8'h00, 8'(k), 8'h00);
      pix_end();
      expect_words('{32'h0201_0403}, "next field");
      $display("test field latch done");
      axi_write(A_CTL, 8'h10);
      axi_write(A_FMT, 8'h14);
      field(1'b1);
      for (int i = 0; i < 4; i++) pix(8'(16 + i), 8'(32 + i), 8'(48 + i), 8'h00, 8'h00);
      pix_end();
      expect_words('{32'h3110_2030, 32'h2232_1121, 32'h1323_3312}, "rgb24 packing");
      field(1'b0);
      pix(8'h00, 8'h00, 8'h00, 8'h40, 8'h5a);
      pix(8'h00, 8'h00, 8'h00, 8'h41, 8'h5a);
      pix_end();
      expect_words('{32'ha541_5a40}, "yuv422 packing");
      $display("test packing done");
      axi_write(A_FMT, 8'h20);
      for (int i = 0; i < 2; i++) begin
         axi_write(A_CTL, i[0] ? 8'h10 : 8'h30);
         field(1'b1);
         repeat (2) pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
         pix_end();
         expect_words('{i[0] ? 32'h1126_1106 : 32'h1106_1106}, "rgb16 diffusion");
      end
      axi_write(A_CTL, 8'h50);
      axi_write(A_FMT, 8'h00);
      field(1'b1);
      pix(8'h11, 8'h22, 8'h33, 8'h00, 8'h00);
      pix_end();
      expect_words('{32'h0000_0000}, "colour bar");
      $display("test diffusion and bars done");
      axi_write(A_FMT, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge aclk);
         gpio_spi16_mode <= i[1];
         decoder_625 <= i[0] ^ i[1];
         axi_write(A_CTL, {i[1] & i[0], 7'h00});
         axi_read(A_STAT);
         cmp_word(32'(rd[6]), 32'(i[0]), "effective standard");
         field(1'b1);
         pix(8'h80, 8'h80, 8'h80, 8'h00, 8'h00);
         pix_end();
         expect_words('{i[0] ? 32'h0020_2020 : 32'h0040_4040}, "gamma removal");
      end
      $display("test gamma done");
      summarize();
   end
endmodule // test_capture_pixel_formatter
